// ==== shared/cds_map.svh ====
// Register map, field positions, reset values and encodings
`ifndef CDS_MAP_SVH
`define CDS_MAP_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CDS_OFS_CACHE   12'h000
`define CDS_OFS_DRAM    12'h004
`define CDS_OFS_STAT    12'h008
// ----------------------------------------------------------------------
// Cache register fields
// ----------------------------------------------------------------------
`define CDS_CEN_BIT     0
`define CDS_CSZ_LO      1
`define CDS_CSZ_HI      2
`define CDS_CWW_BIT     3
// ----------------------------------------------------------------------
// DRAM register fields
// ----------------------------------------------------------------------
`define CDS_SRG_LO      0
`define CDS_SRG_HI      1
`define CDS_PGM_BIT     2
`define CDS_SEN_BIT     3
`define CDS_DWS_LO      4
`define CDS_DWS_HI      5
// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define CDS_ST_BUSY     0
`define CDS_ST_RSV      1
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CDS_RST_CACHE   4'h0
`define CDS_RST_DRAM    6'h00
// ----------------------------------------------------------------------
// Address windows (bits 19:16 of a memory address)
// ----------------------------------------------------------------------
`define CDS_SEG_C       4'hC
`define CDS_SEG_E       4'hE
`define CDS_SEG_F       4'hF
// ----------------------------------------------------------------------
// Wait-state counts
// ----------------------------------------------------------------------
`define CDS_WS_ONE      2'h1
`define CDS_WS_TWO      2'h2
`define CDS_WS_THREE    2'h3
`define CDS_WS_NONE     2'h0
`endif

// ==== shared/cds_pkg.sv ====
// Types shared by the cache/DRAM/shadow configuration block
package cds_pkg;
  typedef enum logic [1:0] {
    CDS_CSZ_NONE  = 2'b00,
    CDS_CSZ_32K   = 2'b01,
    CDS_CSZ_64K   = 2'b10,
    CDS_CSZ_INT   = 2'b11
  } cds_csize_e;
  typedef enum logic [1:0] {
    CDS_SRG_F     = 2'b00,
    CDS_SRG_CF    = 2'b01,
    CDS_SRG_EF    = 2'b10,
    CDS_SRG_RSV   = 2'b11
  } cds_shreg_e;
  typedef enum logic [1:0] {
    CDS_DWS_2     = 2'b00,
    CDS_DWS_1     = 2'b01,
    CDS_DWS_RSV   = 2'b10,
    CDS_DWS_3     = 2'b11
  } cds_dws_e;
  typedef enum logic [1:0] {
    CDS_IDLE      = 2'b00,
    CDS_WAIT      = 2'b01,
    CDS_DONE      = 2'b10
  } cds_cyc_e;
endpackage

// ==== verilog/cds_wait_ctr.sv ====
// Wait-state counter for one memory cycle
module cds_wait_ctr #(
  parameter int W = 2
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              busy,
  output logic              done
);
  logic [W-1:0] cnt_r;
  logic         busy_r;
  wire  [W-1:0] zero_w = '0;
  wire          last_w = busy_r && (cnt_r == zero_w);
  assign busy = busy_r;
  assign done = last_w;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end else if (load) begin
      cnt_r  <= count;
      busy_r <= 1'b1;
    end else if (last_w) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r  <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ==== verilog/cds_cfg.sv ====
// Cache, DRAM and shadow configuration with APB access and cycle steering
module cds_cfg
  import cds_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mem_start,
  input  wire logic        mem_write,
  input  wire logic [19:0] mem_addr,
  output logic             mem_busy,
  output logic             mem_done,
  output logic             use_cache,
  output logic             use_ext_cache,
  output logic             from_shadow,
  output logic             to_rom,
  output logic             page_mode,
  output logic [1:0]       cache_size,
  output logic             cfg_reserved
);
`include "cds_map.svh"
  // --------------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------------
  logic [3:0]  cache_r;
  logic [5:0]  dram_r;
  wire         acc_w   = psel && penable;
  wire         sel_c_w = (paddr == `CDS_OFS_CACHE);
  wire         sel_d_w = (paddr == `CDS_OFS_DRAM);
  wire         sel_s_w = (paddr == `CDS_OFS_STAT);
  wire         mapped_w = sel_c_w || sel_d_w || sel_s_w;
  wire         wr_c_w  = acc_w && pwrite && sel_c_w;
  wire         wr_d_w  = acc_w && pwrite && sel_d_w;
  logic [31:0] rd_w;
  // --------------------------------------------------------------------
  // Field decode from the live registers
  // --------------------------------------------------------------------
  wire             cen_w = cache_r[`CDS_CEN_BIT];
  wire cds_csize_e csz_w = cds_csize_e'(cache_r[`CDS_CSZ_HI:`CDS_CSZ_LO]);
  wire             cww_w = cache_r[`CDS_CWW_BIT];
  wire cds_shreg_e srg_w = cds_shreg_e'(dram_r[`CDS_SRG_HI:`CDS_SRG_LO]);
  wire             pgm_w = dram_r[`CDS_PGM_BIT];
  wire             sen_w = dram_r[`CDS_SEN_BIT];
  wire cds_dws_e   dws_w = cds_dws_e'(dram_r[`CDS_DWS_HI:`CDS_DWS_LO]);
  // --------------------------------------------------------------------
  // Per-cycle snapshot: a config write never reaches a running cycle
  // --------------------------------------------------------------------
  logic       cen_q, pgm_q, sen_q, cww_q;
  logic [1:0] csz_q, srg_q, dws_q;
  logic       wr_q;
  logic [3:0] seg_q;
  logic       busy_w, done_w;
  wire        take_w = mem_start && !busy_w;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cache_r <= `CDS_RST_CACHE;
      dram_r  <= `CDS_RST_DRAM;
    end else begin
      if (wr_c_w)
        cache_r <= pwdata[`CDS_CWW_BIT:`CDS_CEN_BIT];
      if (wr_d_w)
        dram_r  <= pwdata[`CDS_DWS_HI:`CDS_SRG_LO];
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cen_q <= 1'b0;
      pgm_q <= 1'b0;
      sen_q <= 1'b0;
      cww_q <= 1'b0;
      csz_q <= 2'h0;
      srg_q <= 2'h0;
      dws_q <= 2'h0;
      wr_q  <= 1'b0;
      seg_q <= 4'h0;
    end else if (take_w) begin
      cen_q <= cen_w;
      pgm_q <= pgm_w;
      sen_q <= sen_w;
      cww_q <= cww_w;
      csz_q <= csz_w;
      srg_q <= srg_w;
      dws_q <= dws_w;
      wr_q  <= mem_write;
      seg_q <= mem_addr[19:16];
    end
  end
  // --------------------------------------------------------------------
  // Routing of the captured cycle
  // --------------------------------------------------------------------
  wire cache_on_w = cen_q && (cds_csize_e'(csz_q) != CDS_CSZ_NONE);
  wire ext_w      = cache_on_w &&
                    ((cds_csize_e'(csz_q) == CDS_CSZ_32K) ||
                     (cds_csize_e'(csz_q) == CDS_CSZ_64K));
  wire in_f_w     = (seg_q == `CDS_SEG_F);
  wire in_c_w     = (seg_q == `CDS_SEG_C);
  wire in_e_w     = (seg_q == `CDS_SEG_E);
  logic in_reg_w;
  always_comb begin
    in_reg_w = 1'b0;
    unique case (cds_shreg_e'(srg_q))
      CDS_SRG_F:   in_reg_w = in_f_w;
      CDS_SRG_CF:  in_reg_w = in_f_w || in_c_w;
      CDS_SRG_EF:  in_reg_w = in_f_w || in_e_w;
      CDS_SRG_RSV: in_reg_w = 1'b0;
    endcase
  end
  // Reserved shadow code shadows nothing, so ROM stays reachable
  wire rom_area_w = in_f_w || in_c_w || in_e_w;
  wire shadow_w   = sen_q && in_reg_w && !wr_q;
  // --------------------------------------------------------------------
  // Wait states for the captured cycle
  // --------------------------------------------------------------------
  wire        wr_cache_w = wr_q && cache_on_w;
  logic [1:0] ws_w;
  always_comb begin
    ws_w = `CDS_WS_TWO;
    if (wr_cache_w)
      ws_w = cww_q ? `CDS_WS_NONE : `CDS_WS_ONE;
    else begin
      unique case (cds_dws_e'(dws_q))
        CDS_DWS_2:   ws_w = `CDS_WS_TWO;
        CDS_DWS_1:   ws_w = `CDS_WS_ONE;
        CDS_DWS_3:   ws_w = `CDS_WS_THREE;
        CDS_DWS_RSV: ws_w = `CDS_WS_THREE;
      endcase
    end
  end
  // Count is loaded one cycle after take, from the snapshot
  logic load_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      load_r <= 1'b0;
    else
      load_r <= take_w;
  end
  logic pend_w;
  assign pend_w = load_r;
  cds_wait_ctr #(.W(2)) u_wait (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .load    (load_r),
    .count   (ws_w),
    .busy    (),
    .done    (done_w)
  );
  logic run_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      run_r <= 1'b0;
    else if (take_w)
      run_r <= 1'b1;
    else if (done_w)
      run_r <= 1'b0;
  end
  assign busy_w = run_r || pend_w;
  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign mem_busy      = busy_w;
  assign mem_done      = done_w;
  assign use_cache     = cache_on_w;
  assign use_ext_cache = ext_w;
  assign from_shadow   = shadow_w;
  assign to_rom        = rom_area_w && !shadow_w && !wr_q;
  assign page_mode     = pgm_q;
  assign cache_size    = csz_q;
  assign cfg_reserved  = (srg_w == CDS_SRG_RSV) || (dws_w == CDS_DWS_RSV);
  always_comb begin
    rd_w = 32'h0000_0000;
    if (sel_c_w)
      rd_w[`CDS_CWW_BIT:`CDS_CEN_BIT] = cache_r;
    else if (sel_d_w)
      rd_w[`CDS_DWS_HI:`CDS_SRG_LO] = dram_r;
    else if (sel_s_w) begin
      rd_w[`CDS_ST_BUSY] = busy_w;
      rd_w[`CDS_ST_RSV]  = cfg_reserved;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_w;
  end
  assign pready  = 1'b1;
  assign pslverr = acc_w && !mapped_w;
  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  property p_cache_off;
    @(posedge sys_clk) disable iff (!rstn)
      !cen_q |-> !use_cache && !use_ext_cache;
  endproperty
  a_cache_off: assert property (p_cache_off)
    else $error("cache used while disabled");
  property p_ext;
    @(posedge sys_clk) disable iff (!rstn)
      use_ext_cache |-> (csz_q == CDS_CSZ_32K || csz_q == CDS_CSZ_64K);
  endproperty
  a_ext: assert property (p_ext)
    else $error("external cache with wrong size code");
  property p_cwait0;
    @(posedge sys_clk) disable iff (!rstn)
      (take_w && mem_write && cen_w && csz_w != CDS_CSZ_NONE && cww_w)
      |-> ##2 mem_done;
  endproperty
  a_cwait0: assert property (p_cwait0)
    else $error("zero-wait cache write not done in time");
  property p_cwait1;
    @(posedge sys_clk) disable iff (!rstn)
      (take_w && mem_write && cen_w && csz_w != CDS_CSZ_NONE && !cww_w)
      |-> ##2 !mem_done ##1 mem_done;
  endproperty
  a_cwait1: assert property (p_cwait1)
    else $error("one-wait cache write timing wrong");
  property p_region;
    @(posedge sys_clk) disable iff (!rstn)
      (srg_q == CDS_SRG_F && in_c_w) |-> !from_shadow;
  endproperty
  a_region: assert property (p_region)
    else $error("C segment shadowed with F-only region");
  property p_page;
    @(posedge sys_clk) disable iff (!rstn)
      take_w |=> page_mode == $past(pgm_w);
  endproperty
  a_page: assert property (p_page)
    else $error("page mode not taken from config");
  property p_shadow;
    @(posedge sys_clk) disable iff (!rstn)
      !sen_q |-> !from_shadow;
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("shadow read while disabled");
  property p_dws3;
    @(posedge sys_clk) disable iff (!rstn)
      (take_w && !mem_write && dws_w == CDS_DWS_3)
      |-> ##2 (!mem_done)[*3] ##1 mem_done;
  endproperty
  a_dws3: assert property (p_dws3)
    else $error("three DRAM wait states not honoured");
  property p_hold;
    @(posedge sys_clk) disable iff (!rstn)
      (busy_w && !take_w) |=> $stable(dws_q) && $stable(cen_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("snapshot changed during a cycle");
  c_shadow: cover property (@(posedge sys_clk) disable iff (!rstn)
    from_shadow);
  c_ext: cover property (@(posedge sys_clk) disable iff (!rstn)
    use_ext_cache && mem_done);
  c_wr_mid: cover property (@(posedge sys_clk) disable iff (!rstn)
    busy_w && wr_d_w);
endmodule

// ==== verification/cds_fw_model.sv ====
// Firmware-side model that programs the configuration block over APB
module cds_fw_model
  import cds_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hung;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    hung = 1'b0;
  end

  // ------------------------------------------------------------------
  // One transfer; called just after a rising edge, returns after one
  // idle edge so a following call never reassigns psel in one step
  // ------------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) hung = 1'b1;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Defaults go in before any memory traffic
  task automatic load_defaults();
    logic [31:0] q;
    logic        e;
    xfer(1'b1, 12'h000, 32'h0000_0000, q, e);
    xfer(1'b1, 12'h004, 32'h0000_0000, q, e);
  endtask
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the cache/DRAM/shadow configuration block
module tb
  import cds_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, rstn = 1'b0;
  logic mem_start = 1'b0, mem_write = 1'b0;
  logic [19:0] mem_addr = 20'h00000;
  logic psel, penable, pwrite, pready, pslverr, mem_busy, mem_done;
  logic use_cache, use_ext_cache, from_shadow, to_rom, page_mode;
  logic cfg_reserved;
  logic [1:0]  cache_size;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int fails = 0, n_checks = 0, seed = 32'h13f206a7;
  logic [3:0] ccfg, segs [4] = '{4'hC, 4'hE, 4'hF, 4'h3};
  logic [5:0] dcfg;
  logic       prev_cen;

  always #12.5 sys_clk = ~sys_clk;

  cds_cfg i_cds_cfg (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_start(mem_start), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_busy(mem_busy), .mem_done(mem_done), .use_cache(use_cache),
    .use_ext_cache(use_ext_cache), .from_shadow(from_shadow),
    .to_rom(to_rom), .page_mode(page_mode), .cache_size(cache_size),
    .cfg_reserved(cfg_reserved));
  cds_fw_model u_fw (.sys_clk(sys_clk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  // ------------------------------------------------------------------
  // Reporting
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic        e;
    u_fw.xfer(wr, a, d, q, e);
    if (u_fw.hung) begin
      fails++;
      finish_test();
    end
    chk({31'h0, e}, {31'h0, ee});
    if (!wr) chk(q, d);
  endtask

  // Waits expected: cache writes use the write-wait bit, else DRAM code
  function automatic int waits(logic wr, logic [3:0] c, logic [5:0] d);
    // Cache write timing only applies while a cache is really in use
    if (wr && c[0] && c[2:1] != 2'b00) return c[3] ? 0 : 1;
    case (d[5:4])
      2'b00:   return 2;
      2'b01:   return 1;
      default: return 3;
    endcase
  endfunction
  function automatic logic shadowed(logic wr, logic [5:0] d, logic [3:0] s);
    if (wr || !d[3]) return 1'b0;
    return (d[1:0] != 2'b11 && s == 4'hF) ||
           (d[1:0] == 2'b01 && s == 4'hC) || (d[1:0] == 2'b10 && s == 4'hE);
  endfunction

  task automatic mem_cyc(input logic wr, input logic [3:0] s);
    int k;
    mem_start <= 1'b1;
    mem_write <= wr;
    mem_addr <= {s, 16'($random(seed))};
    @(posedge sys_clk);
    mem_start <= 1'b0;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
      #1;
    end while (mem_done !== 1'b1 && k < 20);
    if (k == 20) begin
      fails++;
      finish_test();
    end
    // k counts edges after the take edge, so zero waits gives one
    chk(k, 1 + waits(wr, ccfg, dcfg));
    chk(mem_busy, 1'b1);
    chk(use_cache, ccfg[0] && ccfg[2:1] != 2'b00);
    chk(use_ext_cache,
        ccfg[0] && (ccfg[2:1] == 2'b01 || ccfg[2:1] == 2'b10));
    chk(cache_size, ccfg[2:1]);
    chk(page_mode, dcfg[2]);
    chk(from_shadow, shadowed(wr, dcfg, s));
    chk(to_rom, !wr && (s == 4'hC || s == 4'hE || s == 4'hF) &&
        !shadowed(wr, dcfg, s));
    @(posedge sys_clk);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    bus(1'b0, 12'h000, 32'h0000_0000, 1'b0);
    bus(1'b0, 12'h004, 32'h0000_0000, 1'b0);
    u_fw.load_defaults();
    bus(1'b1, 12'h00C, 32'hFFFF_FFFF, 1'b1);
    bus(1'b0, 12'h010, 32'h0000_0000, 1'b1);
    for (int i = 0; i < 32; i++) begin
      prev_cen = ccfg[0] && ccfg[2:1] != 2'b00;
      ccfg = {4'($random(seed))} | {3'h0, i[4]};
      ccfg[2:1] = i[3:2];
      dcfg = 6'($random(seed));
      dcfg[5:4] = i[1:0];
      bus(1'b1, 12'h000, {28'h0, ccfg}, 1'b0);
      bus(1'b1, 12'h004, {26'h0, dcfg}, 1'b0);
      if (i > 0) chk(use_cache, prev_cen);
      chk(cfg_reserved, dcfg[1:0] == 2'b11 || dcfg[5:4] == 2'b10);
      bus(1'b0, 12'h000, {28'h0, ccfg}, 1'b0);
      bus(1'b0, 12'h004, {26'h0, dcfg}, 1'b0);
      bus(1'b0, 12'h008, {30'h0, dcfg[1:0] == 2'b11 || dcfg[5:4] == 2'b10,
          1'b0}, 1'b0);
      mem_cyc(1'($random(seed)), segs[i % 4]);
      mem_cyc(1'b1, segs[(i + 1) % 4]);
      mem_cyc(1'b0, segs[(i + 2) % 4]);
    end
    finish_test();
  end

  initial begin
    #2000000;
    fails++;
    finish_test();
  end
endmodule
